// [hw/ulpi_fifo.sv]
// Purpose: flop based fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   no bypass, a word is readable the cycle after it is written
module ulpi_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output      logic         in_ready,
   output      logic         out_valid,
   output      logic [W-1:0] out_data,
   input  wire logic         out_ready
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   if (D < 2 || (1 << AW) != D) begin : g_chk
      $error("fifo depth must be a power of two of at least 2");
   end

   logic [W-1:0] mem_q [D];
   logic [W-1:0] mem_d [D];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   ////////////////////////////////////////////////////////////////////////
   // honest full and empty from the fill count
   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer and count update
   always_comb begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d        = wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clk) begin
      mem_q <= mem_d;
   end
endmodule

// [hw/ulpi_if.sv]
// Purpose: ulpi pins between the phy end and the link end
// Assumes: data bus has pull-downs, stop line a weak pull-up
// Notes:   wire levels are resolved here from the output enables
interface ulpi_if;
   logic       ulpi_clk;
   logic       dir;
   logic       nxt;
   logic       stp_drv;
   logic       stp_oe;
   logic [7:0] phy_dout;
   logic       phy_oe;
   logic [7:0] link_dout;
   logic       link_oe;
   logic       stp;
   logic [7:0] data;

   // weak pull-up on the stop line
   assign stp = stp_oe ? stp_drv : 1'b1;

   // shared data bus, pulled down when nobody drives
   assign data = phy_oe ? phy_dout : (link_oe ? link_dout : 8'h00);

   modport phy (
      output ulpi_clk, dir, nxt, phy_dout, phy_oe,
      input  stp, data
   );

   modport link (
      input  ulpi_clk, dir, nxt, data,
      output stp_drv, stp_oe, link_dout, link_oe
   );
endinterface

// [hw/ulpi_link_end.sv]
// Purpose: link end of the ulpi port, transmit fifo and receive capture
// Assumes: first word of each packet is a nonzero transmit command
// Notes:   interface clock is sampled, its edges found on clk
module ulpi_link_end
   import ulpi_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic       clk,
   input  wire logic       rst,
   ulpi_if.link            u,
   input  wire logic       in_valid,
   input  wire logic [7:0] in_data,
   input  wire logic       in_last,
   output      logic       in_ready,
   output      logic       rx_valid,
   output      logic [7:0] rx_data,
   output      logic       rx_cmd
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   link_state_t state_q, state_d;
   logic [10:0] pin_s1, pin_s2;
   logic        clk_s3;
   logic        uclk_s, dir_s, nxt_s, rise, fall;
   logic [7:0]  data_s;
   logic        f_valid, f_ready;
   logic [8:0]  f_data;
   logic [7:0]  dout_q, dout_d;
   logic        stp_q, stp_d;
   logic        stpoe_q;
   logic        dirp_q, dirp_d;
   logic        turn_q, turn_d;
   logic        dird_q;
   logic        rxv_q, rxv_d;
   logic [7:0]  rxd_q, rxd_d;
   logic        rxc_q, rxc_d;

   ////////////////////////////////////////////////////////////////////////
   // two-flop sync of phy pins plus edge finder on the clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 11'h000;
         pin_s2 <= 11'h000;
         clk_s3 <= 1'b0;
      end else begin
         pin_s1 <= {u.ulpi_clk, u.dir, u.nxt, u.data};
         pin_s2 <= pin_s1;
         clk_s3 <= pin_s2[10];
      end
   end

   assign uclk_s = pin_s2[10];
   assign dir_s  = pin_s2[9];
   assign nxt_s  = pin_s2[8];
   assign data_s = pin_s2[7:0];
   assign rise   = uclk_s && !clk_s3;
   assign fall   = !uclk_s && clk_s3;

   ////////////////////////////////////////////////////////////////////////
   // transmit buffer: packet bytes with an end marker in bit 8
   ulpi_fifo #(
      .W (9),
      .D (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (in_valid),
      .in_data   ({in_last, in_data}),
      .in_ready  (in_ready),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_ready)
   );

   ////////////////////////////////////////////////////////////////////////
   // transmit, stop and receive capture
   always_comb begin
      state_d = state_q;
      dout_d  = dout_q;
      stp_d   = stp_q;
      dirp_d  = dirp_q;
      turn_d  = turn_q;
      rxv_d   = 1'b0;
      rxd_d   = rxd_q;
      rxc_d   = rxc_q;
      f_ready = 1'b0;
      // dir seen falling: stay off the bus until the next fall
      if (dird_q && !dir_s) begin
         turn_d = 1'b1;
      end else if (fall) begin
         turn_d = 1'b0;
      end
      if (rise) begin
         dirp_d = dir_s;
         if (dir_s && dirp_q) begin
            rxv_d = 1'b1;
            rxd_d = data_s;
            rxc_d = !nxt_s;                      // unthrottled rx command
         end
      end
      unique case (state_q)
         L_IDLE: begin
            if (fall && f_valid && !dir_s && !dird_q && !turn_q) begin
               state_d = L_TX;
               dout_d  = f_data[7:0];
            end else if (fall) begin
               dout_d = BUS_IDLE;
            end
         end
         L_TX: begin
            if (rise && dir_s) begin
               state_d = L_IDLE;              // phy took the bus, retry
               dout_d  = BUS_IDLE;
            end else if (rise && nxt_s) begin
               f_ready = 1'b1;
               if (f_data[8]) begin
                  state_d = L_STOP;
               end
            end else if (fall && f_valid) begin
               dout_d = f_data[7:0];
            end
         end
         L_STOP: begin
            if (fall) begin
               state_d = L_DONE;
               stp_d   = 1'b1;
               dout_d  = BUS_IDLE;
            end
         end
         L_DONE: begin
            if (fall) begin
               state_d = L_IDLE;
               stp_d   = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= L_IDLE;
         dout_q  <= 8'h00;
         stp_q   <= 1'b0;
         stpoe_q <= 1'b0;
         dirp_q  <= 1'b0;
         turn_q  <= 1'b0;
         dird_q  <= 1'b0;
         rxv_q   <= 1'b0;
         rxd_q   <= 8'h00;
         rxc_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         dout_q  <= dout_d;
         stp_q   <= stp_d;
         stpoe_q <= 1'b1;
         dirp_q  <= dirp_d;
         turn_q  <= turn_d;
         dird_q  <= dir_s;
         rxv_q   <= rxv_d;
         rxd_q   <= rxd_d;
         rxc_q   <= rxc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive: release data at once when dir rises, wait a turn when it falls
   assign u.link_oe   = !dir_s && !dird_q && !turn_q;
   assign u.link_dout = dout_q;
   assign u.stp_drv   = stp_q;
   assign u.stp_oe    = stpoe_q;
   assign rx_valid    = rxv_q;
   assign rx_data     = rxd_q;
   assign rx_cmd      = rxc_q;
endmodule

// [hw/ulpi_phy_end.sv]
// Purpose: phy end of the ulpi port, bus master and clock source
// Assumes: user side signals are on clk; stop and data pins are not
// Notes:   interface clock is clk divided by 2*HALF
//
// Contract
// - phy is always bus master
// - phy generates and outputs the interface clock
// - all bus signals timed on interface clock (here low power data follows usb_line_state and usb_int with no clock)
// - no interface clock in low power mode
// - link drives data to zero when idle
// - eight bit data, one byte per rising edge
// - dir low means link drives, high phy
// - link raises stop to end transmit
// - stop comes cycle after last byte
// - stop input pulled up, undriven means no command
// - next throttles all but rx command, read data
// - rx start raises dir and next together
// - next low on first transmit command cycle
// - synchronous mode after reset, low power other
// - low power: dir high, line state, interrupt
// - aux clock output carries oob clock in u3
module ulpi_phy_end
   import ulpi_pkg::*;
#(
   parameter int HALF = ULPI_HALF_DEF
) (
   input  wire logic       clk,
   input  wire logic       rst,
   ulpi_if.phy             u,
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_data,
   output      logic       rx_ready,
   input  wire logic       tx_ready,
   output      logic       tx_valid,
   output      logic [7:0] tx_data,
   output      logic       tx_stop,
   input  wire logic       lp_req,
   input  wire logic [1:0] usb_line_state,
   input  wire logic       usb_int,
   output      logic       lp_active,
   input  wire logic       u3,
   input  wire logic       out_of_band_clock,
   output      logic       aux_clock_output
);
   if (HALF < ULPI_HALF_MIN || HALF > ULPI_HALF_MAX) begin : g_chk
      $error("HALF must lie between ULPI_HALF_MIN and ULPI_HALF_MAX");
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations
   phy_state_t state_q, state_d;
   logic [7:0] cnt_q, cnt_d;
   logic       uclk_q, uclk_d;
   logic       run, wrap, rise, fall;
   logic       dir_q, dir_d;
   logic       nxt_q, nxt_d;
   logic [7:0] dout_q, dout_d;
   logic       txv_q, txv_d;
   logic [7:0] txd_q, txd_d;
   logic       txs_q, txs_d;
   logic [8:0] pin_s1, pin_s2;
   logic       stp_s;
   logic [7:0] data_s;
   logic       low_power_interrupt_out;
   logic       low_power_line_state_hi;
   logic       low_power_line_state_lo;

   ////////////////////////////////////////////////////////////////////////
   // two-flop sync of the pins the link drives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 9'h1ff;
         pin_s2 <= 9'h1ff;
      end else begin
         pin_s1 <= {u.stp, u.data};
         pin_s2 <= pin_s1;
      end
   end

   assign stp_s  = pin_s2[8];
   assign data_s = pin_s2[7:0];

   ////////////////////////////////////////////////////////////////////////
   // interface clock divider, halted while parked in low power
   always_comb begin
      run  = !(state_q == P_LP && lp_req);
      wrap = run && (cnt_q == 8'(HALF - 1));
      rise = wrap && !uclk_q;
      fall = wrap && uclk_q;
      if (!run) begin
         cnt_d  = 8'h00;
         uclk_d = 1'b0;
      end else if (wrap) begin
         cnt_d  = 8'h00;
         uclk_d = !uclk_q;
      end else begin
         cnt_d  = cnt_q + 8'h01;
         uclk_d = uclk_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q  <= 8'h00;
         uclk_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         uclk_q <= uclk_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus state machine: launch on falling, sample on rising interface edge
   always_comb begin
      state_d  = state_q;
      dir_d    = dir_q;
      nxt_d    = nxt_q;
      dout_d   = dout_q;
      txv_d    = 1'b0;
      txd_d    = txd_q;
      txs_d    = 1'b0;
      rx_ready = 1'b0;
      unique case (state_q)
         P_IDLE: begin
            // idle bus reads zero; nonzero byte without stop is a command
            if (rise && !stp_s && data_s != BUS_IDLE) begin
               state_d = P_TXCMD;
               nxt_d   = 1'b0;
            end else if (fall && rx_valid) begin
               state_d = P_RXTURN;
               dir_d   = 1'b1;
               nxt_d   = 1'b1;
            end else if (fall && lp_req) begin
               state_d = P_LPTURN;
               dir_d   = 1'b1;
            end
         end
         P_TXCMD: begin
            if (fall) begin
               state_d = P_TXDAT;
               nxt_d   = tx_ready;
            end
         end
         P_TXDAT: begin
            if (rise && stp_s) begin
               state_d = P_IDLE;
               nxt_d   = 1'b0;
               txs_d   = 1'b1;
            end else if (rise && nxt_q) begin
               txv_d = 1'b1;
               txd_d = data_s;
            end else if (fall) begin
               nxt_d = tx_ready;
            end
         end
         P_RXTURN: begin
            if (fall && rx_valid) begin
               state_d  = P_RXDAT;
               dout_d   = rx_data;
               rx_ready = 1'b1;
            end else if (fall) begin
               state_d = P_TURNIN;
               dir_d   = 1'b0;
               nxt_d   = 1'b0;
            end
         end
         P_RXDAT: begin
            if (fall && rx_valid) begin
               dout_d   = rx_data;
               rx_ready = 1'b1;
               nxt_d    = 1'b1;
            end else if (fall) begin
               state_d = P_TURNIN;
               dir_d   = 1'b0;
               nxt_d   = 1'b0;
            end
         end
         P_TURNIN: begin
            if (fall) begin
               state_d = P_IDLE;
            end
         end
         P_LPTURN: begin
            if (fall) begin
               state_d = P_LP;
            end
         end
         P_LP: begin
            if (fall) begin
               state_d = P_TURNIN;
               dir_d   = 1'b0;
            end
         end
         default: begin
            state_d = P_IDLE;
            dir_d   = 1'b0;
            nxt_d   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= P_IDLE;
         dir_q   <= 1'b0;
         nxt_q   <= 1'b0;
         dout_q  <= 8'h00;
         txv_q   <= 1'b0;
         txd_q   <= 8'h00;
         txs_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         dir_q   <= dir_d;
         nxt_q   <= nxt_d;
         dout_q  <= dout_d;
         txv_q   <= txv_d;
         txd_q   <= txd_d;
         txs_q   <= txs_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // low power pin reuse, straight from the sources
   assign low_power_interrupt_out = usb_int;
   assign low_power_line_state_hi = usb_line_state[1];
   assign low_power_line_state_lo = usb_line_state[0];

   // pin drive: clock, direction and next always come from here
   always_comb begin
      u.ulpi_clk = uclk_q;
      u.dir      = dir_q;
      u.nxt      = nxt_q;
      u.phy_oe   = dir_q && (state_q == P_RXDAT || state_q == P_LP);
      u.phy_dout = dout_q;
      if (state_q == P_LP) begin
         u.phy_dout           = 8'h00;
         u.phy_dout[LP_INT]   = low_power_interrupt_out;
         u.phy_dout[LP_LS_HI] = low_power_line_state_hi;
         u.phy_dout[LP_LS_LO] = low_power_line_state_lo;
      end
   end

   // user side outputs
   assign tx_valid  = txv_q;
   assign tx_data   = txd_q;
   assign tx_stop   = txs_q;
   assign lp_active = (state_q == P_LP);

   // out-of-band clock passes only in u3
   assign aux_clock_output = u3 ? out_of_band_clock : 1'b0;
endmodule

// [hw/ulpi_pkg.sv]
// Purpose: shared constants and state types of both ulpi port ends
// Assumes: system clock of 40 MHz on both ends
// Notes:   interface clock is divided from the system clock
package ulpi_pkg;
   ////////////////////////////////////////////////////////////////////////
   // timing: target interface clock and what the divider can really reach
   localparam int SYS_CLK_MHZ    = 40;
   localparam int ULPI_CLK_MHZ   = 60;
   localparam int ULPI_HALF_CALC = SYS_CLK_MHZ / (2 * ULPI_CLK_MHZ);
   localparam int ULPI_HALF_MIN  = 6;   // two-flop sync latency both ways
   localparam int ULPI_HALF_DEF  = (ULPI_HALF_CALC > 8) ? ULPI_HALF_CALC : 8;
   localparam int ULPI_HALF_MAX  = 255;

   ////////////////////////////////////////////////////////////////////////
   // bus layout
   localparam int         DATA_W     = 8;
   localparam int         FIFO_DEPTH = 8;
   localparam logic [7:0] BUS_IDLE   = 8'h00;
   localparam int         LP_LS_LO   = 0;   // line state bit 0
   localparam int         LP_LS_HI   = 1;   // line state bit 1
   localparam int         LP_INT     = 3;   // low power interrupt bit

   ////////////////////////////////////////////////////////////////////////
   // state machines
   typedef enum logic [2:0] {
      P_IDLE   = 3'h0,
      P_TXCMD  = 3'h1,
      P_TXDAT  = 3'h3,
      P_RXTURN = 3'h2,
      P_RXDAT  = 3'h6,
      P_TURNIN = 3'h7,
      P_LPTURN = 3'h5,
      P_LP     = 3'h4
   } phy_state_t;

   typedef enum logic [1:0] {
      L_IDLE = 2'h0,
      L_TX   = 2'h1,
      L_STOP = 2'h3,
      L_DONE = 2'h2
   } link_state_t;
endpackage

// [tb/tb.sv]
// Purpose: both ulpi ends face to face, user sides checked
// Assumes: interface half period cut to 6 clk cycles
// Notes:   inputs change on the falling clk edge
module tb import ulpi_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] cmd;
      logic [7:0] dat;
   } row_t;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       oob = 1'b0;
   logic       rx_valid, rx_ready, tx_ready, tx_valid, tx_stop, lp_req;
   logic       usb_int, lp_active, u3, aux, in_valid, in_last, in_ready;
   logic       lrx_valid, rx_cmd;
   logic [7:0] rx_data, tx_data, in_data, lrx_data;
   logic [1:0] usb_line_state;
   logic [7:0] got[$];
   logic [7:0] rgot[$];
   int         n_fail, n_checks, n_stop;
   row_t       rows[4] = '{'{8'h41, 8'h5a}, '{8'h42, 8'ha5},
                           '{8'h43, 8'hff}, '{8'h4f, 8'h01}};

   always #12.5 clk = ~clk;
   always #100 oob = ~oob;
   ////////////////////////////////////////////////////////////////////////
   // both ends, wires and checker
   ulpi_if ulpi_if_inst ();
   ulpi_phy_end #(.HALF(6)) ulpi_phy_end_inst (
      .clk(clk), .rst(rst), .u(ulpi_if_inst.phy),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_stop(tx_stop), .lp_req(lp_req), .usb_line_state(usb_line_state),
      .usb_int(usb_int), .lp_active(lp_active), .u3(u3),
      .out_of_band_clock(oob), .aux_clock_output(aux));
   ulpi_link_end ulpi_link_end_inst (
      .clk(clk), .rst(rst), .u(ulpi_if_inst.link),
      .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
      .in_ready(in_ready), .rx_valid(lrx_valid), .rx_data(lrx_data),
      .rx_cmd(rx_cmd));
   ulpi_port_chk #(.HALF(6)) ulpi_port_chk_inst (
      .clk(clk), .rst(rst), .ulpi_clk(ulpi_if_inst.ulpi_clk),
      .dir(ulpi_if_inst.dir), .nxt(ulpi_if_inst.nxt),
      .stp(ulpi_if_inst.stp), .phy_oe(ulpi_if_inst.phy_oe),
      .link_oe(ulpi_if_inst.link_oe), .data(ulpi_if_inst.data));
   ////////////////////////////////////////////////////////////////////////
   // collect bytes and stops seen at the user sides
   always @(negedge clk) begin
      if (tx_valid === 1'b1) got.push_back(tx_data);
      if (tx_stop === 1'b1) n_stop++;
      if (lrx_valid === 1'b1) rgot.push_back(lrx_data);
   end

   // compare and count
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // push a packet into the link fifo, last byte flagged
   task automatic send(input logic [7:0] b[$]);
      for (int i = 0; i < b.size(); i++) begin
         in_valid = 1'b1;
         in_data = b[i];
         in_last = (i == b.size() - 1);
         while (in_ready !== 1'b1) @(negedge clk);
         @(negedge clk);
      end
      in_valid = 1'b0;
      in_last = 1'b0;
   endtask

   // bounded wait for a count of stops
   task automatic wait_stop(int n);
      for (int i = 0; i < 400 && n_stop < n; i++) @(negedge clk);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // hang guard
   initial begin
      #300000;
      n_fail++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int         k;
      logic [7:0] q[$];
      {rx_valid, lp_req, usb_int, u3, in_valid, in_last} = 6'h00;
      tx_ready = 1'b1;
      {rx_data, in_data, usb_line_state} = 18'h00000;
      repeat (10) @(negedge clk);
      check("stp in reset", {7'h0, ulpi_if_inst.stp}, 8'h01);
      rst = 1'b0;
      @(negedge clk);
      check("dir", {7'h0, ulpi_if_inst.dir}, 8'h00);
      check("idle bus", ulpi_if_inst.data, BUS_IDLE);
      check("in_ready", {7'h0, in_ready}, 8'h01);
      // ordinary two byte packets
      foreach (rows[i]) begin
         got.delete();
         send('{rows[i].cmd, rows[i].dat});
         wait_stop(i + 1);
         check("tx count", 8'(got.size()), 8'h02);
         check("tx cmd", got[0], rows[i].cmd);
         check("tx data", got[1], rows[i].dat);
         check("tx stop", 8'(n_stop), 8'(i + 1));
      end
      // stalled phy: fifo fills and refuses, then drains
      tx_ready = 1'b0;
      got.delete();
      for (k = 0; k < 8; k++) q.push_back(8'h81 + 8'(k));
      send(q);
      repeat (60) @(negedge clk);
      check("full", {7'h0, in_ready}, 8'h00);
      check("stalled", 8'(got.size()), 8'h00);
      tx_ready = 1'b1;
      wait_stop(5);
      check("drain", 8'(got.size()), 8'h08);
      check("last", got[7], 8'h88);
      check("stops", 8'(n_stop), 8'h05);
      // one received byte
      rx_data = 8'hc3;
      rx_valid = 1'b1;
      for (k = 0; k < 100 && rx_ready !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      rx_valid = 1'b0;
      repeat (60) @(negedge clk);
      check("rx byte", rgot[0], 8'hc3);
      check("rx kind", {7'h0, rx_cmd}, 8'h00);
      check("rx count", 8'(rgot.size()), 8'h01);
      // low power entry, pins reused, exit
      lp_req = 1'b1;
      usb_line_state = 2'h2;
      usb_int = 1'b1;
      for (k = 0; k < 100 && lp_active !== 1'b1; k++) @(negedge clk);
      repeat (30) @(negedge clk);
      check("lp bus", ulpi_if_inst.data, 8'h0a);
      check("lp dir", {7'h0, ulpi_if_inst.dir}, 8'h01);
      check("lp clock", {7'h0, ulpi_if_inst.ulpi_clk}, 8'h00);
      check("lp active", {7'h0, lp_active}, 8'h01);
      usb_line_state = 2'h1;
      usb_int = 1'b0;
      #1;
      check("lp follow", ulpi_if_inst.data, 8'h01);
      @(negedge clk);
      lp_req = 1'b0;
      for (k = 0; k < 100 && lp_active !== 1'b0; k++) @(negedge clk);
      repeat (30) @(negedge clk);
      check("sync dir", {7'h0, ulpi_if_inst.dir}, 8'h00);
      check("sync active", {7'h0, lp_active}, 8'h00);
      // aux clock output: quiet outside u3, out-of-band clock in u3
      for (k = 0; k < 8; k++) begin
         #70;
         check("aux clk", {7'h0, aux}, {7'h0, oob & u3});
         if (k == 3) begin
            @(negedge clk);
            u3 = 1'b1;
         end
      end
      // reset in the middle of a packet, then a clean packet
      @(negedge clk);
      send('{8'h44, 8'h55});
      repeat (20) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      check("rst stp", {7'h0, ulpi_if_inst.stp}, 8'h01);
      check("rst dir", {7'h0, ulpi_if_inst.dir}, 8'h00);
      rst = 1'b0;
      @(negedge clk);
      check("rst idle", ulpi_if_inst.data, BUS_IDLE);
      check("rst fifo", {7'h0, in_ready}, 8'h01);
      got.delete();
      k = n_stop;
      send('{8'h46, 8'h66});
      wait_stop(k + 1);
      check("rst tx", got[1], 8'h66);
      check("rst stop", 8'(n_stop - k), 8'h01);
      close_out();
   end
endmodule

// [tb/ulpi_port_chk.sv]
// Purpose: protocol checks on the ulpi wires
// Assumes: interface clock half period is HALF clk cycles
// Notes:   all checks on clk, off in reset
module ulpi_port_chk #(
   parameter int HALF = 8
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       ulpi_clk,
   input wire logic       dir,
   input wire logic       nxt,
   input wire logic       stp,
   input wire logic       phy_oe,
   input wire logic       link_oe,
   input wire logic [7:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TURN = 2 * HALF;
   localparam int TAIL = TURN - 7;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // clock and direction
   chk_clk_half: assert property (
      $changed(ulpi_clk) && !dir |-> ##HALF $changed(ulpi_clk))
      else $error("interface clock half period off");
   chk_phy_drive_dir: assert property (phy_oe |-> dir)
      else $error("phy drives data with dir low");
   chk_no_contention: assert property (phy_oe |-> !link_oe)
      else $error("both ends drive data");
   chk_turn_phy_quiet: assert property (
      $changed(dir) |-> !phy_oe [*8])
      else $error("phy drives in turnaround");
   chk_turn_link_quiet: assert property (
      $rose(dir) |-> ##6 !link_oe [*6])
      else $error("link drives in turnaround");
   chk_turn_link_fall: assert property (
      $fell(dir) |-> !link_oe [*8] ##1 !link_oe [*4])
      else $error("link drives in turnaround after dir fell");
   chk_rx_start_pair: assert property (
      $rose(dir) && nxt |-> $rose(nxt))
      else $error("next not raised with dir");
   ////////////////////////////////////////////////////////////////////////
   // transmit handshakes
   chk_cmd_no_nxt: assert property (
      !dir && $past(data) == 8'h00 && data != 8'h00 |-> !nxt [*8])
      else $error("next high on first command cycle");
   chk_stop_data_zero: assert property (
      $rose(stp) |-> data == 8'h00)
      else $error("data not zero with stop");
   chk_stop_one_cycle: assert property (
      $rose(stp) |-> stp [*8] ##TAIL !stp)
      else $error("stop not one interface cycle");
   chk_stop_after_byte: assert property (
      $rose(stp) |-> $past(data, TURN) != 8'h00)
      else $error("stop not right after last byte");
   // main scenarios
   cov_tx: cover property ($rose(stp));
   cov_rx: cover property ($rose(dir) && nxt);
   cov_lp: cover property ($rose(dir) && !nxt);
endmodule
